/* core/sync_burst_sram_port_regs.svh */
`ifndef SYNC_BURST_SRAM_PORT_REGS_SVH
`define SYNC_BURST_SRAM_PORT_REGS_SVH

// Array shape: 256K words of four 9-bit lanes (8 data bits + 1 parity)
`define SBP_ADDR_W 18
`define SBP_UPPER_W 16
`define SBP_DEPTH 262144
`define SBP_LANE_W 9
`define SBP_LANES 4
`define SBP_DATA_W 36

// Burst counter
`define SBP_CNT_W 2
`define SBP_CNT_ZERO 2'h0
`define SBP_CNT_ONE 2'h1

// Lane enables
`define SBP_LANES_ALL 4'hF
`define SBP_LANES_NONE 4'h0

// Burst-order strap: low selects linear, high or open selects interleaved
`define SBP_ORDER_LINEAR 1'h0
`define SBP_ORDER_INTERLEAVED 1'h1

`endif

/* core/sync_burst_sram_port_pkg.sv */
`include "sync_burst_sram_port_regs.svh"

package sync_burst_sram_port_pkg;

	typedef logic [`SBP_UPPER_W-1:0] upper_t;
	typedef logic [`SBP_ADDR_W-1:0] addr_t;
	typedef logic [`SBP_DATA_W-1:0] data_t;
	typedef logic [`SBP_CNT_W-1:0] cnt_t;
	typedef logic [`SBP_LANES-1:0] lanes_t;

	// Port state: deselected, or inside a burst
	typedef enum logic [1:0] {
		ST_DESEL = 2'b00,
		ST_ACTIVE = 2'b01
	} port_state_e;

endpackage : sync_burst_sram_port_pkg

/* core/sync_burst_sram_port.sv */
// Notes on behaviour
// R1: The address is captured only when a strobe is low and all chip selects are active.
// R2: The two low address bits load a 2-bit burst counter that then supplies them.
// R3: With all-lanes write high, a lane is written only when its select is low and the lane qualifier is low.
// R4: A low all-lanes write writes every lane regardless of selects and qualifier.
// R5: Inside a burst the counter steps when advance is low and holds otherwise.
// R6: The port is selected only with select one low, two high and three low.
// R7: The processor strobe is ignored while select one is high.
// R8: Output enable acts without the clock: low drives data, high floats the pins.
// R9: The first read clock after a deselect keeps the outputs undriven.
// R10: A processor strobe latches the full address and starts a new burst.
// R11: A controller strobe latches the full address and loads the counter too.
// R12: With both strobes low and select one low only the processor strobe is acted upon.
// R13: The burst-order strap selects linear when low, interleaved when high.
// R14: Read data is that of the location addressed at the preceding edge.
// R15: Linear order adds the count with wrap; interleaved XORs it with the base.
`timescale 1ns/1ps
`include "sync_burst_sram_port_regs.svh"

module sync_burst_sram_port (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire sync_burst_sram_port_pkg::upper_t addr_upper_i,
	input wire logic addr_bit_one_i,
	input wire logic addr_bit_zero_i,
	input wire logic processor_addr_strobe_n_i,
	input wire logic controller_addr_strobe_n_i,
	input wire logic burst_advance_n_i,
	input wire logic all_lanes_write_n_i,
	input wire logic lane_write_qualifier_n_i,
	input wire logic lane_select_a_n_i,
	input wire logic lane_select_b_n_i,
	input wire logic lane_select_c_n_i,
	input wire logic lane_select_d_n_i,
	input wire logic chip_sel_one_n_i,
	input wire logic chip_sel_two_i,
	input wire logic chip_sel_three_n_i,
	input wire logic output_enable_n_i,
	input wire logic burst_order_i,
	input wire sync_burst_sram_port_pkg::data_t dq_i,
	output logic [`SBP_DATA_W-1:0] dq_o,
	output logic dq_oe_o
);
	import sync_burst_sram_port_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Burst address sequence
	function automatic cnt_t burst_low(input cnt_t base, input cnt_t cnt,
		input logic order);
		if (order == `SBP_ORDER_LINEAR) begin
			burst_low = cnt_t'(base + cnt); // R15
		end else begin
			burst_low = base ^ cnt; // R15
		end
	endfunction : burst_low

	port_state_e state_q, state_d;
	upper_t upper_q, upper_d;
	cnt_t base_q, base_d;
	cnt_t cnt_q, cnt_d;
	logic order_q;
	logic order_taken_q;
	logic read_q;
	logic mask_q;
	data_t rd_data_q;
	data_t mem [0:`SBP_DEPTH-1];

	////////////////////////////////////////////////////////////////////////
	// Select and strobe decode
	wire selected = ~chip_sel_one_n_i & chip_sel_two_i
		& ~chip_sel_three_n_i; // R6
	wire proc_take = ~processor_addr_strobe_n_i & ~chip_sel_one_n_i; // R7
	wire ctrl_take = ~controller_addr_strobe_n_i & ~proc_take; // R12
	wire strobe = proc_take | ctrl_take;
	wire start = strobe & selected; // R1
	wire deselect = strobe & ~selected;
	wire in_burst = (state_q == ST_ACTIVE);
	wire cont = in_burst & ~strobe;
	wire advance = cont & ~burst_advance_n_i; // R5

	// Lane write qualification
	wire [`SBP_LANES-1:0] lane_sel = ~{lane_select_d_n_i, lane_select_c_n_i,
		lane_select_b_n_i, lane_select_a_n_i};
	wire [`SBP_LANES-1:0] byte_we = lane_write_qualifier_n_i ?
		`SBP_LANES_NONE : lane_sel; // R3
	wire [`SBP_LANES-1:0] lane_we = all_lanes_write_n_i ?
		byte_we : `SBP_LANES_ALL; // R4
	// A processor-strobed start is always a read; writes follow in the burst
	wire wr_en = ((start & ctrl_take) | cont) & (|lane_we);
	wire rd_en = (start | cont) & ~wr_en;

	// Next address and counter
	always_comb begin
		state_d = state_q;
		upper_d = upper_q;
		base_d = base_q;
		cnt_d = cnt_q;
		if (start) begin
			state_d = ST_ACTIVE; // R10
			upper_d = addr_upper_i; // R10 R11
			base_d = {addr_bit_one_i, addr_bit_zero_i}; // R2 R11
			cnt_d = `SBP_CNT_ZERO; // R2
		end else if (deselect) begin
			state_d = ST_DESEL;
		end else if (advance) begin
			cnt_d = cnt_t'(cnt_q + `SBP_CNT_ONE); // R5
		end
	end

	wire cnt_t low_d = burst_low(base_d, cnt_d, order_q); // R2
	wire addr_t addr_d = {upper_d, low_d};

	////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= ST_DESEL;
			upper_q <= '0;
			base_q <= `SBP_CNT_ZERO;
			cnt_q <= `SBP_CNT_ZERO;
		end else begin
			state_q <= state_d;
			upper_q <= upper_d;
			base_q <= base_d;
			cnt_q <= cnt_d;
		end
	end

	// Strap sampled once at the first edge after reset release
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			order_q <= `SBP_ORDER_INTERLEAVED;
			order_taken_q <= 1'b0;
		end else if (!order_taken_q) begin
			order_q <= burst_order_i; // R13
			order_taken_q <= 1'b1;
		end
	end

	// Read data and output masking
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			read_q <= 1'b0;
			mask_q <= 1'b0;
			rd_data_q <= '0;
		end else begin
			read_q <= rd_en;
			mask_q <= rd_en & (state_q == ST_DESEL); // R9
			if (rd_en) begin
				rd_data_q <= mem[addr_d]; // R14
			end
		end
	end

	// Array write, lane by lane
	always_ff @(posedge core_clk_i) begin
		for (int l = 0; l < `SBP_LANES; l++) begin
			if (wr_en && lane_we[l]) begin
				mem[addr_d][l*`SBP_LANE_W +: `SBP_LANE_W] <=
					dq_i[l*`SBP_LANE_W +: `SBP_LANE_W]; // R3 R4
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive; enable follows output enable without the clock
	assign dq_o = rd_data_q;
	assign dq_oe_o = read_q & ~mask_q & ~output_enable_n_i; // R8 R9

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_CAPTURE_NEEDS_SELECT: assert property ( // R1
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(strobe && !selected) |=> (state_q == ST_DESEL))
		else $error("strobe without select did not deselect");

	AST_COUNTER_LOAD: assert property ( // R2
		@(posedge core_clk_i) disable iff (!reset_n_i)
		start |=> (cnt_q == `SBP_CNT_ZERO
			&& base_q == $past({addr_bit_one_i, addr_bit_zero_i})))
		else $error("burst counter not loaded at capture");

	AST_LANE_QUALIFIER: assert property ( // R3
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(all_lanes_write_n_i && lane_write_qualifier_n_i) |-> !wr_en)
		else $error("lane write without qualifier");

	AST_ALL_LANES: assert property ( // R4
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(!all_lanes_write_n_i && cont) |-> (wr_en && lane_we == `SBP_LANES_ALL))
		else $error("all-lanes write did not cover every lane");

	AST_ADVANCE_STEP: assert property ( // R5
		@(posedge core_clk_i) disable iff (!reset_n_i)
		cont |=> (cnt_q == ($past(burst_advance_n_i) ? $past(cnt_q)
			: cnt_t'($past(cnt_q) + `SBP_CNT_ONE))))
		else $error("burst counter step wrong");

	AST_PROC_IGNORED: assert property ( // R7
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(chip_sel_one_n_i && controller_addr_strobe_n_i) |-> !strobe)
		else $error("processor strobe taken with select one high");

	AST_OE_ASYNC: assert property ( // R8
		@(posedge core_clk_i) disable iff (!reset_n_i)
		output_enable_n_i |-> !dq_oe_o)
		else $error("pins driven with output enable high");

	AST_FIRST_READ_MASK: assert property ( // R9
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(state_q == ST_DESEL && start && !wr_en) |=> !dq_oe_o)
		else $error("first read after deselect was driven");

	AST_PROC_PRIORITY: assert property ( // R12
		@(posedge core_clk_i) disable iff (!reset_n_i)
		(proc_take && selected) |-> (start && !wr_en))
		else $error("controller strobe acted despite processor strobe");

endmodule : sync_burst_sram_port

/* sim/bus_side_model.sv */
`timescale 1ns/1ps
// Far-side master: passes device data when driven, else drives write data, else the inverse of the last pin value
module bus_side_model (
	input wire logic clk_i,
	input wire logic drive_i,
	input wire sync_burst_sram_port_pkg::data_t wdata_i,
	input wire sync_burst_sram_port_pkg::data_t pins_i,
	input wire logic pins_oe_i,
	output sync_burst_sram_port_pkg::data_t pins_o
);
	import sync_burst_sram_port_pkg::*;
	data_t last_q;
	// Last pin value, so a released bus never looks stable
	always_ff @(posedge clk_i) begin
		last_q <= pins_o;
	end
	// Pins: device first, then master, else the inverse of the last value
	assign pins_o = pins_oe_i ? pins_i : drive_i ? wdata_i : ~last_q;
endmodule : bus_side_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import sync_burst_sram_port_pkg::*;
	logic clk = 0, rst_n = 0, a1 = 0, a0 = 0, p_n = 1, c_n = 1;
	logic adv_n = 1, gw_n = 1, bwe_n = 1, s1_n = 1, s2 = 0, s3_n = 1;
	logic oe_n = 1, ord = 0, drv = 0, chk = 0, chk_d = 0, inb = 0, doe;
	upper_t up = '0;
	lanes_t sel_n = 4'hF;
	data_t wd = '0, din, dout;
	data_t mem[addr_t];
	logic [37:0] q[$];
	logic [37:0] e;
	addr_t base;
	cnt_t cnt;
	int error_cnt = 0, n_checks = 0;
	logic [31:0] rs = 32'h0000CE43;
	// 25 MHz clock
	always #20 clk = ~clk;
	sync_burst_sram_port u_dut (.core_clk_i(clk), .reset_n_i(rst_n),
		.addr_upper_i(up), .addr_bit_one_i(a1), .addr_bit_zero_i(a0),
		.processor_addr_strobe_n_i(p_n), .controller_addr_strobe_n_i(c_n),
		.burst_advance_n_i(adv_n), .all_lanes_write_n_i(gw_n),
		.lane_write_qualifier_n_i(bwe_n), .lane_select_a_n_i(sel_n[0]),
		.lane_select_b_n_i(sel_n[1]), .lane_select_c_n_i(sel_n[2]),
		.lane_select_d_n_i(sel_n[3]), .chip_sel_one_n_i(s1_n),
		.chip_sel_two_i(s2), .chip_sel_three_n_i(s3_n),
		.output_enable_n_i(oe_n), .burst_order_i(ord), .dq_i(din),
		.dq_o(dout), .dq_oe_o(doe));
	bus_side_model u_bus (.clk_i(clk), .drive_i(drv), .wdata_i(wd),
		.pins_i(dout), .pins_oe_i(doe), .pins_o(din));
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	task automatic cmp_d(input data_t x);
		n_checks++;
		if (dout !== x) begin
			error_cnt++;
			$display("[FAIL] dq_o exp %h got %h", x, dout);
		end
	endtask : cmp_d
	task automatic cmp_oe(input logic x);
		n_checks++;
		if (doe !== x) begin
			error_cnt++;
			$display("[FAIL] dq_oe_o exp %b got %b", x, doe);
		end
	endtask : cmp_oe
	// One cycle; g, b, v are the low-active write, qualifier, advance
	task automatic cyc(input logic p, c, s, g, b, v, input addr_t na);
		logic [31:0] r;
		logic k1, ps, go, mk, ok, rd;
		lanes_t ln;
		addr_t ad;
		data_t m, w;
		r = rnd();
		w = {r[3:0], rnd()};
		k1 = ~s & ~(r[0] ^ r[1]);
		ps = p & ~k1;
		go = ps | c;
		mk = go & s & ~inb;
		if (go & ~s) inb = 0;
		else if (go) begin
			base = na;
			cnt = 2'h0;
			inb = 1;
		end else if (inb & ~v) cnt = cnt + 2'h1;
		ad = {base[17:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
		ln = (ps | ~inb) ? 4'h0 : ~g ? 4'hF : ~b ? ~r[7:4] : 4'h0;
		m = mem.exists(ad) ? mem[ad] : 'x;
		for (int l = 0; l < 4; l++) if (ln[l]) m[9*l+:9] = w[9*l+:9];
		if (ln != 0) mem[ad] = m;
		rd = inb & ln == 0;
		ok = ^m !== 1'bx;
		if (rd) q.push_back({ok, mk, m});
		@(posedge clk);
		up <= na[17:2];
		a1 <= na[1];
		a0 <= na[0];
		p_n <= ~p;
		c_n <= ~c;
		gw_n <= g;
		bwe_n <= b;
		adv_n <= v;
		sel_n <= r[7:4];
		s1_n <= k1;
		s2 <= s | r[1:0] != 2'h1;
		s3_n <= ~s & r[1:0] == 2'h2;
		oe_n <= r[8] | ln != 0;
		drv <= ln != 0;
		wd <= w;
		chk <= rd;
	endtask : cyc
	// A read shows one edge after its cycle; enable follows the pin now
	always @(posedge clk) chk_d <= chk;
	// Data is compared only where the word is known; no read, no drive
	always @(negedge clk) begin
		if (chk_d) begin
			e = q.pop_front();
			if (e[37]) cmp_d(e[35:0]);
			cmp_oe(~oe_n & ~e[36]);
		end else begin
			cmp_oe(1'b0);
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : finish_test
	// Watchdog
	initial begin
		#400000;
		error_cnt++;
		finish_test();
	end
	// Each burst order: fill, read back, deselect, random traffic
	initial begin
		addr_t a;
		logic [31:0] r;
		for (int o = 0; o < 2; o++) begin
			rst_n <= 0;
			ord <= o[0];
			repeat (8) @(posedge clk);
			rst_n <= 1;
			repeat (2) @(posedge clk);
			a = addr_t'(rnd());
			for (int i = 0; i < 8; i++)
				cyc(0, i % 4 == 0, 1, 0, 1, 0, a ^ addr_t'(i));
			for (int i = 0; i < 6; i++) cyc(i == 0, 0, 1, 1, 1, i[0], a);
			cyc(0, 1, 0, 1, 1, 0, a);
			cyc(1, 1, 1, 0, 1, 0, a ^ 18'h4);
			for (int i = 0; i < 80; i++) begin
				r = rnd();
				cyc(r[0], r[1], r[3:2] != 0, r[4], r[5], r[6], {a[17:3], r[9:7]});
			end
			cyc(0, 1, 0, 1, 1, 1, a);
			repeat (2) @(posedge clk);
			$display("burst order %0d done", o);
		end
		finish_test();
	end
endmodule : tb_top
